// [pcl_pkg.sv]
package pcl_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CLK_NS = 10;
   localparam int POR_MS = 4;
   localparam int POR_CYC = POR_MS * CLK_MHZ * 1000;
   localparam int STATUS_LOW_US = 268;
   localparam int STATUS_LOW_CYC = STATUS_LOW_US * CLK_MHZ;
   localparam int CFG_LOW_US = 2;
   localparam int CFG_LOW_CYC = CFG_LOW_US * CLK_MHZ;
   localparam int ST2CK_US = 2;
   localparam int ST2CK_CYC = ST2CK_US * CLK_MHZ;
   localparam int INIT_CYCLES = 17408;
   localparam int CD2UM_US = 175;
   localparam int CD2UM_CYC = CD2UM_US * CLK_MHZ;
   localparam int LCLK_MIN_NS = 8;
   localparam int CU_CYC = (4 * LCLK_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int HALF_CYC = 4;
   localparam int DATA_W = 16;
   localparam int IMAGE_WORDS = 16;
   // ----------------------------------------
   // controller registers
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] DATA_OFF = 8'h04;
   localparam logic [7:0] STAT_OFF = 8'h08;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_W16_BIT = 1;
   localparam int CTRL_ENC_BIT = 2;
   localparam int CTRL_CMP_BIT = 3;
   localparam int DATA_LAST_BIT = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STATUS_BIT = 1;
   localparam int STAT_LC_BIT = 2;
   localparam int STAT_DONE_BIT = 3;
   localparam int STAT_FULL_BIT = 4;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // load clocks per data word
   function automatic logic [2:0] ratio(input logic w16, input logic enc, input logic cmp);
      logic [2:0] r;
      r = 3'h1;
      if (cmp) begin
         r = w16 ? 3'h4 : 3'h2;
      end else if (w16 && enc) begin
         r = 3'h2;
      end
      return r;
   endfunction
endpackage

// [pcl_link_if.sv]
interface pcl_link_if;
   logic config_req_n;
   logic status_n;
   logic load_complete;
   logic init_done;
   logic load_clock;
   logic [pcl_pkg::DATA_W-1:0] data;
   modport dev(input config_req_n, input load_clock, input data,
               output status_n, output load_complete, output init_done);
   modport host(output config_req_n, output load_clock, output data,
                input status_n, input load_complete, input init_done);
endinterface

// [pcl_dev.sv]
module pcl_dev #(
   parameter int POR_CYCLES = pcl_pkg::POR_CYC,
   parameter int STATUS_CYCLES = pcl_pkg::STATUS_LOW_CYC,
   parameter int INIT_CLKS = pcl_pkg::INIT_CYCLES,
   parameter int OSC_CYCLES = pcl_pkg::CD2UM_CYC,
   parameter int WORDS = pcl_pkg::IMAGE_WORDS
) (
   input wire logic pclk,
   input wire logic presetn,
   pcl_link_if.dev link,
   input wire logic width16,
   input wire logic encrypt,
   input wire logic compress,
   input wire logic user_clk_sel,
   input wire logic init_done_en,
   input wire logic user_init_clock,
   output logic [pcl_pkg::DATA_W-1:0] cfg_word,
   output logic cfg_word_valid,
   output logic user_mode
);
   import pcl_pkg::*;

   typedef enum logic [7:0] {
      ST_POR = 8'h01,
      ST_HOLD = 8'h02,
      ST_STLOW = 8'h04,
      ST_LOAD = 8'h08,
      ST_FALLS = 8'h10,
      ST_CU = 8'h20,
      ST_INIT = 8'h40,
      ST_USER = 8'h80
   } pcl_dev_st_t;

   localparam int SW = DATA_W + 3;
   localparam int LCLK = DATA_W + 1;
   localparam int REQ = DATA_W;
   localparam int UCLK = DATA_W + 2;

   pcl_dev_st_t st_q, st_d;
   logic [SW-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;
   logic [19:0] cnt_q, cnt_d;
   logic [15:0] wc_q, wc_d;
   logic [2:0] sub_q, sub_d;
   logic fc_q, fc_d;
   logic status_q, status_d;
   logic lc_q, lc_d;
   logic idn_q, idn_d;
   logic um_q, um_d;
   logic [DATA_W-1:0] word_q, word_d;
   logic wv_q, wv_d;
   logic lrise, lfall, urise, req_low, inc;
   logic [2:0] r, sub_n;
   logic [15:0] wc_n;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s1_d = {user_init_clock, link.load_clock, link.config_req_n, link.data};
      s2_d = s1_q;
      s3_d = s2_q;
      // a bit changes once the second and third stages agree
      lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      lrise = lvl_d[LCLK] & ~lvl_q[LCLK];
      lfall = ~lvl_d[LCLK] & lvl_q[LCLK];
      urise = lvl_d[UCLK] & ~lvl_q[UCLK];
      req_low = ~lvl_q[REQ];
      r = ratio(width16, encrypt, compress);
      st_d = st_q;
      cnt_d = cnt_q;
      wc_d = wc_q;
      sub_d = sub_q;
      fc_d = fc_q;
      status_d = status_q;
      lc_d = lc_q;
      idn_d = idn_q;
      um_d = um_q;
      word_d = word_q;
      wv_d = 1'b0;
      sub_n = sub_q + 3'h1;
      wc_n = wc_q;
      inc = 1'b0;
      case (st_q)
         ST_POR: begin
            cnt_d = cnt_q + 20'h1;
            if (cnt_q == 20'(POR_CYCLES - 1)) begin
               cnt_d = 20'h0;
               status_d = ~req_low;
               st_d = req_low ? ST_HOLD : ST_LOAD;
            end
         end
         ST_HOLD: begin
            if (!req_low) begin
               cnt_d = 20'h0;
               st_d = ST_STLOW;
            end
         end
         ST_STLOW: begin
            cnt_d = cnt_q + 20'h1;
            if (cnt_q == 20'(STATUS_CYCLES - 1)) begin
               status_d = 1'b1;
               st_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (lrise) begin
               if (sub_q == 3'h0) begin
                  word_d = width16 ? lvl_d[DATA_W-1:0] : {8'h00, lvl_d[7:0]};
                  wv_d = 1'b1;
                  wc_n = wc_q + 16'h1;
               end
               wc_d = wc_n;
               sub_d = sub_n;
               if (sub_n == r) begin
                  sub_d = 3'h0;
                  if (wc_n == 16'(WORDS)) begin
                     lc_d = 1'b1;
                     idn_d = ~init_done_en;
                     fc_d = 1'b0;
                     st_d = ST_FALLS;
                  end
               end
            end
         end
         ST_FALLS: begin
            if (lfall) begin
               fc_d = 1'b1;
               if (fc_q) begin
                  cnt_d = 20'h0;
                  st_d = user_clk_sel ? ST_CU : ST_INIT;
               end
            end
         end
         ST_CU: begin
            cnt_d = cnt_q + 20'h1;
            if (cnt_q == 20'(CU_CYC - 1)) begin
               cnt_d = 20'h0;
               st_d = ST_INIT;
            end
         end
         ST_INIT: begin
            inc = user_clk_sel ? urise : 1'b1;
            if (inc) begin
               cnt_d = cnt_q + 20'h1;
               if (cnt_q == (user_clk_sel ? 20'(INIT_CLKS - 1) : 20'(OSC_CYCLES - 1))) begin
                  idn_d = 1'b1;
                  um_d = 1'b1;
                  st_d = ST_USER;
               end
            end
         end
         ST_USER: begin
         end
         default: begin
            st_d = ST_HOLD;
         end
      endcase
      if (req_low && st_q != ST_POR) begin
         st_d = ST_HOLD;
         status_d = 1'b0;
         lc_d = 1'b0;
         um_d = 1'b0;
         idn_d = 1'b1;
         wc_d = 16'h0;
         sub_d = 3'h0;
         cnt_d = 20'h0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_POR;
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         lvl_q <= '1;
         cnt_q <= 20'h0;
         wc_q <= 16'h0;
         sub_q <= 3'h0;
         fc_q <= 1'b0;
         status_q <= 1'b0;
         lc_q <= 1'b0;
         idn_q <= 1'b1;
         um_q <= 1'b0;
         word_q <= '0;
         wv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
         cnt_q <= cnt_d;
         wc_q <= wc_d;
         sub_q <= sub_d;
         fc_q <= fc_d;
         status_q <= status_d;
         lc_q <= lc_d;
         idn_q <= idn_d;
         um_q <= um_d;
         word_q <= word_d;
         wv_q <= wv_d;
      end
   end

   assign link.status_n = status_q;
   assign link.load_complete = lc_q;
   assign link.init_done = idn_q;
   assign cfg_word = word_q;
   assign cfg_word_valid = wv_q;
   assign user_mode = um_q;
endmodule

// [pcl_host.sv]
// The APB slave port and the register offsets were left to the implementer.
module pcl_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   pcl_link_if.host link
);
   import pcl_pkg::*;

   typedef enum logic [6:0] {
      HS_IDLE = 7'h01,
      HS_REQ = 7'h02,
      HS_WST = 7'h04,
      HS_GAP = 7'h08,
      HS_SEND = 7'h10,
      HS_FIN = 7'h20,
      HS_DONE = 7'h40
   } pcl_host_st_t;

   pcl_host_st_t st_q, st_d;
   logic [2:0] mode_q, mode_d;
   logic [DATA_W-1:0] buf_q, buf_d, data_q, data_d;
   logic bl_q, bl_d, bv_q, bv_d, last_q, last_d, ld_q, ld_d;
   logic [2:0] edges_q, edges_d;
   logic clk_q, clk_d, reqn_q, reqn_d, fall_q, fall_d;
   logic [7:0] div_q, div_d, cnt_q, cnt_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, perr_q, perr_d;
   logic [1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;
   logic tick, acc, mapped;
   logic [2:0] r;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s1_d = {link.load_complete, link.status_n};
      s2_d = s1_q;
      s3_d = s2_q;
      lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      r = ratio(mode_q[0], mode_q[1], mode_q[2]);
      tick = (div_q == 8'(HALF_CYC - 1));
      div_d = tick ? 8'h0 : div_q + 8'h1;
      st_d = st_q;
      mode_d = mode_q;
      buf_d = buf_q;
      bl_d = bl_q;
      bv_d = bv_q;
      data_d = data_q;
      last_d = last_q;
      ld_d = ld_q;
      edges_d = edges_q;
      clk_d = clk_q;
      reqn_d = reqn_q;
      fall_d = fall_q;
      cnt_d = cnt_q;
      case (st_q)
         HS_IDLE, HS_DONE: begin
         end
         HS_REQ: begin
            reqn_d = 1'b0;
            cnt_d = cnt_q + 8'h1;
            if (cnt_q == 8'(CFG_LOW_CYC)) begin
               reqn_d = 1'b1;
               st_d = HS_WST;
            end
         end
         HS_WST: begin
            cnt_d = 8'h0;
            if (lvl_q[0]) begin
               st_d = HS_GAP;
            end
         end
         HS_GAP: begin
            cnt_d = cnt_q + 8'h1;
            if (cnt_q == 8'(ST2CK_CYC - 1)) begin
               st_d = HS_SEND;
            end
         end
         HS_SEND: begin
            if (tick) begin
               if (!clk_q) begin
                  if (ld_q) begin
                     clk_d = 1'b1;
                     edges_d = edges_q + 3'h1;
                  end else if (bv_q) begin
                     // data goes out a half period before the rise
                     data_d = mode_q[0] ? buf_q : {8'h00, buf_q[7:0]};
                     last_d = bl_q;
                     bv_d = 1'b0;
                     ld_d = 1'b1;
                  end
               end else begin
                  clk_d = 1'b0;
                  if (edges_q == r) begin
                     edges_d = 3'h0;
                     ld_d = 1'b0;
                     if (last_q) begin
                        fall_d = 1'b0;
                        st_d = HS_FIN;
                     end
                  end
               end
            end
         end
         HS_FIN: begin
            if (tick && lvl_q[1]) begin
               clk_d = ~clk_q;
               if (clk_q) begin
                  fall_d = 1'b1;
                  if (fall_q) begin
                     st_d = HS_DONE;
                  end
               end
            end
         end
         default: begin
            st_d = HS_IDLE;
         end
      endcase
      // apb: one wait state, data writes stall while the buffer is full
      mapped = (paddr == CTRL_OFF) || (paddr == DATA_OFF) || (paddr == STAT_OFF);
      acc = psel && penable && pready_q;
      pready_d = 1'b0;
      prdata_d = 32'h0;
      perr_d = 1'b0;
      if (psel && penable && !pready_q && !(pwrite && paddr == DATA_OFF && bv_q)) begin
         pready_d = 1'b1;
         perr_d = !mapped;
         if (!pwrite && paddr == CTRL_OFF) begin
            prdata_d = {28'h0, mode_q, 1'b0};
         end else if (!pwrite && paddr == STAT_OFF) begin
            prdata_d[STAT_BUSY_BIT] = !(st_q == HS_IDLE || st_q == HS_DONE);
            prdata_d[STAT_STATUS_BIT] = lvl_q[0];
            prdata_d[STAT_LC_BIT] = lvl_q[1];
            prdata_d[STAT_DONE_BIT] = (st_q == HS_DONE);
            prdata_d[STAT_FULL_BIT] = bv_q;
         end
      end
      if (acc && pwrite && paddr == CTRL_OFF) begin
         mode_d = pwdata[CTRL_CMP_BIT:CTRL_W16_BIT];
         if (pwdata[CTRL_START_BIT] && (st_q == HS_IDLE || st_q == HS_DONE)) begin
            st_d = HS_REQ;
            cnt_d = 8'h0;
            clk_d = 1'b0;
            edges_d = 3'h0;
            ld_d = 1'b0;
         end
      end
      if (acc && pwrite && paddr == DATA_OFF) begin
         buf_d = pwdata[DATA_W-1:0];
         bl_d = pwdata[DATA_LAST_BIT];
         bv_d = 1'b1;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= HS_IDLE;
         mode_q <= CTRL_RESET;
         buf_q <= '0;
         bl_q <= 1'b0;
         bv_q <= 1'b0;
         data_q <= '0;
         last_q <= 1'b0;
         ld_q <= 1'b0;
         edges_q <= 3'h0;
         clk_q <= 1'b0;
         reqn_q <= 1'b1;
         fall_q <= 1'b0;
         div_q <= 8'h0;
         cnt_q <= 8'h0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         perr_q <= 1'b0;
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
         lvl_q <= 2'h0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         buf_q <= buf_d;
         bl_q <= bl_d;
         bv_q <= bv_d;
         data_q <= data_d;
         last_q <= last_d;
         ld_q <= ld_d;
         edges_q <= edges_d;
         clk_q <= clk_d;
         reqn_q <= reqn_d;
         fall_q <= fall_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         perr_q <= perr_d;
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign link.config_req_n = reqn_q;
   assign link.load_clock = clk_q;
   assign link.data = data_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = perr_q;
endmodule

// [pcl_link_properties.sv]
module pcl_link_properties #(
   parameter int POR_CYCLES = 50,
   parameter int STATUS_CYCLES = 40,
   parameter int WORDS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic config_req_n,
   input wire logic status_n,
   input wire logic load_complete,
   input wire logic init_done,
   input wire logic load_clock,
   input wire logic [pcl_pkg::DATA_W-1:0] data
);
   timeunit 1ns;
   timeprecision 100ps;
   import pcl_pkg::*;
   localparam int ST_LIMIT = STATUS_CYCLES + 12;
   logic [19:0] por_q;
   logic [19:0] req_q;
   logic [19:0] low_q;
   logic [19:0] rise_q;
   logic ck_q;

   // ----------------------------------------
   // cycle and load clock rise counters
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_q <= 20'h0;
         req_q <= 20'h0;
         low_q <= 20'h0;
         rise_q <= 20'h0;
         ck_q <= 1'b0;
      end else begin
         if (por_q < 20'hfffff) begin
            por_q <= por_q + 20'h1;
         end
         low_q <= status_n ? 20'h0 : low_q + 20'h1;
         req_q <= config_req_n ? 20'h0 : req_q + 20'h1;
         rise_q <= !status_n ? 20'h0 : rise_q + {19'h0, load_clock & ~ck_q};
         ck_q <= load_clock;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_cfg_drop;
      $fell(config_req_n) |-> ##[1:60] (!status_n && !load_complete);
   endproperty
   a_cfg_drop: assert property (p_cfg_drop) else $error("status not dropped");

   property p_cfg_len;
      $rose(config_req_n) |-> req_q >= CFG_LOW_CYC;
   endproperty
   a_cfg_len: assert property (p_cfg_len) else $error("request low too short");

   property p_por;
      status_n |-> por_q >= POR_CYCLES;
   endproperty
   a_por: assert property (p_por) else $error("status high too early");

   property p_st_min;
      $rose(status_n) |-> low_q >= STATUS_CYCLES;
   endproperty
   a_st_min: assert property (p_st_min) else $error("status low too short");

   property p_st_late;
      $rose(config_req_n) |-> ##[1:ST_LIMIT] status_n;
   endproperty
   a_st_late: assert property (p_st_late) else $error("status late");

   property p_lc_rise;
      $rose(load_complete) |-> status_n && config_req_n && rise_q >= WORDS;
   endproperty
   a_lc_rise: assert property (p_lc_rise) else $error("complete too early");

   property p_idn;
      !init_done |-> load_complete && status_n;
   endproperty
   a_idn: assert property (p_idn) else $error("init low out of place");

   property p_init_len;
      $fell(init_done) |-> !init_done[*8] ##[1:900] init_done;
   endproperty
   a_init_len: assert property (p_init_len) else $error("init length");

   property p_ck_high;
      $rose(load_clock) |-> load_clock[*3];
   endproperty
   a_ck_high: assert property (p_ck_high) else $error("clock high short");

   property p_data_hold;
      load_clock |-> $stable(data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved");
endmodule

// [pcl_bench.sv]
module pcl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pcl_pkg::*;
   localparam int WORDS = 4;
   localparam int POR_T = 50;
   localparam int STAT_T = 40;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic user_init_clock = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic width16, encrypt, compress, user_clk_sel, init_done_en;
   logic [DATA_W-1:0] cfg_word;
   logic cfg_word_valid, user_mode;
   int bad_count = 0;
   int n_compared = 0;
   int rises = 0;
   bit ck_d = 1'b0;
   bit idn_low = 1'b0;
   logic [15:0] seen_q[$];

   always #5 pclk = ~pclk;
   always #62.5 user_init_clock = ~user_init_clock;

   pcl_link_if pcl_link_if_i ();
   pcl_dev #(.POR_CYCLES(POR_T), .STATUS_CYCLES(STAT_T), .INIT_CLKS(8), .OSC_CYCLES(20),
      .WORDS(WORDS)) pcl_dev_i (.pclk(pclk), .presetn(presetn), .link(pcl_link_if_i.dev),
      .width16(width16), .encrypt(encrypt), .compress(compress),
      .user_clk_sel(user_clk_sel), .init_done_en(init_done_en),
      .user_init_clock(user_init_clock), .cfg_word(cfg_word),
      .cfg_word_valid(cfg_word_valid), .user_mode(user_mode));
   pcl_host pcl_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(pcl_link_if_i.host));
   pcl_link_properties #(.POR_CYCLES(POR_T), .STATUS_CYCLES(STAT_T), .WORDS(WORDS))
      pcl_link_properties_i (.pclk(pclk), .presetn(presetn),
      .config_req_n(pcl_link_if_i.config_req_n), .status_n(pcl_link_if_i.status_n),
      .load_complete(pcl_link_if_i.load_complete), .init_done(pcl_link_if_i.init_done),
      .load_clock(pcl_link_if_i.load_clock), .data(pcl_link_if_i.data));

   // ----------------------------------------
   // link monitor
   // ----------------------------------------
   always @(posedge pclk) begin
      if (cfg_word_valid === 1'b1) begin
         seen_q.push_back(cfg_word);
      end
      if (pcl_link_if_i.load_clock === 1'b1 && !ck_d) begin
         rises++;
      end
      ck_d = (pcl_link_if_i.load_clock === 1'b1);
      if (pcl_link_if_i.init_done === 1'b0) begin
         idn_low = 1'b1;
      end
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [15:0] word_of(input int i);
      return 16'ha5c3 ^ (16'h1111 << i);
   endfunction

   task automatic load(input logic w16, enc, cmp, usr, ien);
      int r;
      r = cmp ? (w16 ? 4 : 2) : ((w16 && enc) ? 2 : 1);
      @(posedge pclk);
      width16 <= w16;
      encrypt <= enc;
      compress <= cmp;
      user_clk_sel <= usr;
      init_done_en <= ien;
      seen_q.delete();
      rises = 0;
      idn_low = 1'b0;
      apb(1'b1, CTRL_OFF, {28'h0, cmp, enc, w16, 1'b1});
      for (int i = 0; i < WORDS; i++) begin
         apb(1'b1, DATA_OFF, {15'h0, i == WORDS - 1, word_of(i)});
      end
      for (int n = 0; n < 4000 && user_mode !== 1'b1; n++) begin
         @(posedge pclk);
      end
      chk(user_mode, 1);
      chk(rises, WORDS * r + 2);
      chk(seen_q.size(), WORDS);
      for (int i = 0; i < WORDS; i++) begin
         chk(seen_q[i], w16 ? word_of(i) : word_of(i) & 16'h00ff);
      end
      chk(idn_low, ien);
      chk({pcl_link_if_i.status_n, pcl_link_if_i.load_complete}, 2'h3);
      apb(1'b0, STAT_OFF, 32'h0);
      chk(rd & 32'h1f, 32'he);
      $display("load done w16=%0d enc=%0d cmp=%0d ratio=%0d", w16, enc, cmp, r);
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {width16, encrypt, compress, user_clk_sel, init_done_en} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(pcl_link_if_i.status_n, 0);
      chk(pcl_link_if_i.load_complete, 0);
      apb(1'b0, 8'h3c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, 32'h0);
      repeat (60) @(posedge pclk);
      chk(pcl_link_if_i.status_n, 1);
      $display("reset test done");
      for (int k = 0; k < 8; k++) begin
         load(k[0], k[1], k[2], k[1], k[0] ^ k[2]);
      end
      print_verdict();
   end

   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      $display("unexpected at %0t: timeout got %h expected %h", $time, 1'b1, 1'b0);
      print_verdict();
   end
endmodule
